// file: dfcr_regs.sv
/*
 * Flag status and configuration register bank of a bidirectional dual FIFO.
 * Assumes the host port is synchronous to clk_in and that pointer logic
 * outside supplies word counts and pointer-meet levels.
 */
// Notes on behaviour
// - Status bit 3 direction; 4,5,6,7,12,13,14,15 carry flags; rest reserved.
// - Four offset registers hold thresholds in bits 9..0; bits 15..10 ignored.
// - Each array has empty, almost-empty, almost-full and full flags.
// - Hardware reset and reset-all clear every almost offset to zero.
// - Empty/full and almost-empty/almost-full keep separate update timing.
// - Codes 0 to 7 pick the eight flags in fixed order.
// - Control bit 0 picks separate strobes or data strobe with direction.
// - Control bit 2 picks forward full at read or reread pointer.
// - Control bit 3 picks reverse empty at write or rewrite pointer.
// - Bits 4 and 5 set request and acknowledge pin polarities.
// - Bits 7..6 set request to acknowledge delay of 2 to 5 clocks.
// - Bit 8 sets strobe width to one or two internal clocks.
// - Bit 9 divides the transfer clock by two.
// - Bit 10 selects processor or peripheral role for port b.
// - Routing register resets to reverse full, reverse empty, fwd full, fwd empty.
// - Flags follow word count against depth and offsets.
`timescale 1ns/1ps
module dfcr_regs (
   // Clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      srst_in,
   // Host port
   input  dfcr_pkg::dfcr_bus_type         bus_in,
   output logic [15:0]                    rdata_out,
   // Fill state from pointer logic
   input  wire logic [dfcr_pkg::CW-1:0]   fwd_count_in,
   input  wire logic [dfcr_pkg::CW-1:0]   rev_count_in,
   input  wire logic                      fwd_meet_reread_in,
   input  wire logic                      rev_meet_rewrite_in,
   // Programmable pins
   input  wire logic [5:0]                pio_in,
   output logic      [5:0]                pio_out,
   output logic      [5:0]                pio_oe_out,
   // Flags
   output logic      [3:0]                ext_flag_pins_out,
   // Control to transfer engine
   output dfcr_pkg::dfcr_ctl_type         ctl_out,
   output logic                           dma_read_dir_out,
   output logic                           fwd_reset_out,
   output logic                           rev_reset_out,
   output logic                           dma_reset_out
);
   import dfcr_pkg::*;

   typedef struct packed {
      logic [3:0][OFW-1:0] ofs;
      logic [15:0]         route;
      logic [15:0]         gctl;
      logic [PIOW-1:0]     pio_data;
      logic [PIOW-1:0]     pio_dir;
      logic [2:0]          sel;
      logic                dma_dir;
      logic [15:0]         rdata;
      logic                fwd_rst;
      logic                rev_rst;
      logic                dma_rst;
   } dfcr_state_type;

   dfcr_state_type state;
   dfcr_state_type next_state;
   dfcr_flags_type fwd_flags;
   dfcr_flags_type rev_flags;
   logic [7:0]     flag_vec;
   logic [15:0]    status;
   logic [15:0]    cfg_rd;
   logic           wr_cfg;
   logic           wr_cmd;
   logic [2:0]     op;
   logic [2:0]     arg;

   // Forward and reverse flag generators
   dfcr_flag_gen u_fwd (
      .clk_in           (clk_in),
      .srst_in          (srst_in),
      .count_in         (fwd_count_in),
      .ae_ofs_in        (state.ofs[0]),
      .af_ofs_in        (state.ofs[1]),
      .alt_full_in      (fwd_meet_reread_in),
      .alt_empty_in     (1'b0),
      .use_alt_full_in  (state.gctl[GC_FULL]),
      .use_alt_empty_in (1'b0),
      .flags_out        (fwd_flags)
   );

   dfcr_flag_gen u_rev (
      .clk_in           (clk_in),
      .srst_in          (srst_in),
      .count_in         (rev_count_in),
      .ae_ofs_in        (state.ofs[2]),
      .af_ofs_in        (state.ofs[3]),
      .alt_full_in      (1'b0),
      .alt_empty_in     (rev_meet_rewrite_in),
      .use_alt_full_in  (1'b0),
      .use_alt_empty_in (state.gctl[GC_EMPTY]),
      .flags_out        (rev_flags)
   );

   // Flags in selector-code order
   assign flag_vec = {rev_flags.almost_full, rev_flags.full,
                      rev_flags.almost_empty, rev_flags.empty,
                      fwd_flags.almost_full, fwd_flags.full,
                      fwd_flags.almost_empty, fwd_flags.empty};

   dfcr_flag_route u_route (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .route_in (state.route),
      .flags_in (flag_vec),
      .pins_out (ext_flag_pins_out)
   );

   // Status word assembly, reserved bits zero
   always_comb begin
      status = ZERO16;
      status[ST_DIR] = state.dma_dir;
      status[ST_FE]  = fwd_flags.empty;
      status[ST_FAE] = fwd_flags.almost_empty;
      status[ST_RF]  = rev_flags.full;
      status[ST_RAF] = rev_flags.almost_full;
      status[ST_FF]  = fwd_flags.full;
      status[ST_FAF] = fwd_flags.almost_full;
      status[ST_RE]  = rev_flags.empty;
      status[ST_RAE] = rev_flags.almost_empty;
   end

   // Selected configuration register read mux
   always_comb begin
      cfg_rd = ZERO16;
      case (state.sel)
         CR_ROUTE: cfg_rd = state.route;
         CR_GCTL:  cfg_rd = state.gctl & GC_MASK;
         CR_PIOD: begin
            for (int i = 0; i < PIOW; i++) begin
               cfg_rd[i] = state.pio_dir[i] ? state.pio_data[i] : pio_in[i];
            end
         end
         CR_PIOM:  cfg_rd = {10'h000, state.pio_dir};
         default:  cfg_rd = {6'h00, state.ofs[state.sel[1:0]]};
      endcase
   end

   // Write strobes and command fields
   assign wr_cfg = bus_in.cs && bus_in.wr && (bus_in.addr == ADDR_CFG);
   assign wr_cmd = bus_in.cs && bus_in.wr && (bus_in.addr == ADDR_CMD);
   assign op  = bus_in.wdata[OP_LSB +: 3];
   assign arg = bus_in.wdata[2:0];

   // Register updates, commands and read data
   always_comb begin
      next_state = state;
      next_state.fwd_rst = 1'b0;
      next_state.rev_rst = 1'b0;
      next_state.dma_rst = 1'b0;
      if (wr_cfg) begin
         case (state.sel)
            CR_ROUTE: next_state.route = bus_in.wdata;
            CR_GCTL:  next_state.gctl = bus_in.wdata & GC_MASK;
            CR_PIOD:  next_state.pio_data = bus_in.wdata[PIOW-1:0];
            CR_PIOM:  next_state.pio_dir = bus_in.wdata[PIOW-1:0];
            default:  next_state.ofs[state.sel[1:0]] = bus_in.wdata[OFW-1:0];
         endcase
      end
      if (wr_cmd) begin
         case (op)
            OP_SEL: next_state.sel = arg;
            OP_DIR: begin
               if (state.gctl[GC_MODE]) begin
                  next_state.dma_dir = arg[0];
               end
            end
            OP_RST: begin
               next_state.rev_rst = (arg == RST_REV) || (arg == (RST_REV | RST_FWD))
                                    || (arg == RST_ALL);
               next_state.fwd_rst = (arg == RST_FWD) || (arg == (RST_REV | RST_FWD))
                                    || (arg == RST_ALL);
               next_state.dma_rst = (arg == RST_DMA) || (arg == RST_ALL);
               if (arg == RST_ALL) begin
                  next_state.ofs      = '0;
                  next_state.route    = ROUTE_RST;
                  next_state.gctl     = ZERO16;
                  next_state.pio_data = '0;
                  next_state.pio_dir  = '0;
               end
            end
            default: next_state.sel = state.sel;
         endcase
      end
      if (bus_in.cs && bus_in.rd) begin
         next_state.rdata = (bus_in.addr == ADDR_CMD) ? status : cfg_rd;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state <= '{ofs: '0, route: ROUTE_RST, default: '0};
      end else begin
         state <= next_state;
      end
   end

   // Decoded control fields
   always_comb begin
      ctl_out.strobe_ds         = state.gctl[GC_STYLE];
      ctl_out.fwd_full_reread   = state.gctl[GC_FULL];
      ctl_out.rev_empty_rewrite = state.gctl[GC_EMPTY];
      ctl_out.req_active_low    = state.gctl[GC_REQP];
      ctl_out.ack_active_high   = state.gctl[GC_ACKP];
      ctl_out.ack_delay = DLY_BASE + {1'b0, state.gctl[GC_DLY +: 2]};
      ctl_out.strobe_two        = state.gctl[GC_WID];
      ctl_out.clk_div2          = state.gctl[GC_DIV];
      ctl_out.peripheral        = state.gctl[GC_MODE];
   end

   // Outputs
   assign rdata_out        = state.rdata;
   assign pio_out          = state.pio_data;
   assign pio_oe_out       = state.pio_dir;
   assign dma_read_dir_out = state.dma_dir;
   assign fwd_reset_out    = state.fwd_rst;
   assign rev_reset_out    = state.rev_rst;
   assign dma_reset_out    = state.dma_rst;

   sequence s_reset_all;
      wr_cmd && op == OP_RST && arg == RST_ALL;
   endsequence
   property p_reset_all;
      @(posedge clk_in) disable iff (srst_in)
         s_reset_all |=> (state.ofs == '0 && state.route == ROUTE_RST);
   endproperty
   a_reset_all: assert property (p_reset_all)
      else $error("reset-all did not restore defaults");

   property p_status_rsv;
      @(posedge clk_in) disable iff (srst_in)
         (bus_in.cs && bus_in.rd && bus_in.addr == ADDR_CMD)
         |=> (rdata_out[2:0] == 3'h0 && rdata_out[11:8] == 4'h0);
   endproperty
   a_status_rsv: assert property (p_status_rsv)
      else $error("reserved status bits not zero");

   property p_status_flag;
      @(posedge clk_in) disable iff (srst_in)
         (bus_in.cs && bus_in.rd && bus_in.addr == ADDR_CMD)
         |=> rdata_out[ST_FE] == $past(fwd_flags.empty)
             && rdata_out[ST_RE] == $past(rev_flags.empty);
   endproperty
   a_status_flag: assert property (p_status_flag)
      else $error("status flag bits mismatch");

   property p_gctl_rsv;
      @(posedge clk_in) disable iff (srst_in)
         (state.gctl & ~GC_MASK) == ZERO16;
   endproperty
   a_gctl_rsv: assert property (p_gctl_rsv)
      else $error("unused control bits stored");

   property p_delay;
      @(posedge clk_in) disable iff (srst_in)
         ctl_out.ack_delay == 3'(state.gctl[GC_DLY +: 2]) + 3'h2;
   endproperty
   a_delay: assert property (p_delay)
      else $error("acknowledge delay out of range");

   property p_ofs_write;
      @(posedge clk_in) disable iff (srst_in)
         (wr_cfg && state.sel == 3'h1)
         |=> state.ofs[1] == $past(bus_in.wdata[OFW-1:0]);
   endproperty
   a_ofs_write: assert property (p_ofs_write)
      else $error("offset register write lost");

   property p_pin_default;
      @(posedge clk_in) disable iff (srst_in)
         (state.route == ROUTE_RST) |=> ext_flag_pins_out[0] == $past(fwd_flags.empty);
   endproperty
   a_pin_default: assert property (p_pin_default)
      else $error("pin a does not carry forward empty");

   property p_mode_out;
      @(posedge clk_in) disable iff (srst_in)
         (wr_cfg && state.sel == CR_GCTL) |=> ctl_out.peripheral == $past(bus_in.wdata[GC_MODE]);
   endproperty
   a_mode_out: assert property (p_mode_out)
      else $error("peripheral mode not applied");
endmodule

// file: dfcr_pkg.sv
/*
 * Shared constants and carrier types for the dual-FIFO flag and control
 * register set. Assumes a 16-bit host port with two address lines.
 */
package dfcr_pkg;
   // Array depth and widths
   localparam int unsigned DEPTH = 1024;
   localparam int unsigned CW    = 11;
   localparam int unsigned OFW   = 10;
   localparam logic [CW-1:0] DEPTH_CNT = 11'h400;

   // Host port addresses
   localparam logic [1:0] ADDR_CFG  = 2'h2;
   localparam logic [1:0] ADDR_CMD  = 2'h3;

   // Command word fields: opcode in [5:3], operand in [2:0]
   localparam int unsigned OP_LSB  = 3;
   localparam logic [2:0]  OP_RST  = 3'h0;
   localparam logic [2:0]  OP_SEL  = 3'h1;
   localparam logic [2:0]  OP_DIR  = 3'h2;
   localparam logic [2:0]  RST_REV = 3'h1;
   localparam logic [2:0]  RST_FWD = 3'h2;
   localparam logic [2:0]  RST_DMA = 3'h4;
   localparam logic [2:0]  RST_ALL = 3'h7;

   // Configuration register indexes
   localparam logic [2:0] CR_ROUTE = 3'h4;
   localparam logic [2:0] CR_GCTL  = 3'h5;
   localparam logic [2:0] CR_PIOD  = 3'h6;
   localparam logic [2:0] CR_PIOM  = 3'h7;

   // Status word bit positions
   localparam int unsigned ST_DIR  = 3;
   localparam int unsigned ST_FE   = 4;
   localparam int unsigned ST_FAE  = 5;
   localparam int unsigned ST_RF   = 6;
   localparam int unsigned ST_RAF  = 7;
   localparam int unsigned ST_FF   = 12;
   localparam int unsigned ST_FAF  = 13;
   localparam int unsigned ST_RE   = 14;
   localparam int unsigned ST_RAE  = 15;

   // General control bit positions
   localparam int unsigned GC_STYLE = 0;
   localparam int unsigned GC_FULL  = 2;
   localparam int unsigned GC_EMPTY = 3;
   localparam int unsigned GC_REQP  = 4;
   localparam int unsigned GC_ACKP  = 5;
   localparam int unsigned GC_DLY   = 6;
   localparam int unsigned GC_WID   = 8;
   localparam int unsigned GC_DIV   = 9;
   localparam int unsigned GC_MODE  = 10;
   localparam logic [15:0] GC_MASK  = 16'h07FD;

   // Reset values and misc
   localparam logic [15:0] ROUTE_RST = 16'h6420;
   localparam logic [15:0] ZERO16    = 16'h0000;
   localparam logic [2:0]  DLY_BASE  = 3'h2;
   localparam int unsigned PIOW      = 6;
   localparam int unsigned SELW      = 4;

   // Host port request
   typedef struct packed {
      logic        cs;
      logic        rd;
      logic        wr;
      logic [1:0]  addr;
      logic [15:0] wdata;
   } dfcr_bus_type;

   // Four flags of one array
   typedef struct packed {
      logic almost_full;
      logic full;
      logic almost_empty;
      logic empty;
   } dfcr_flags_type;

   // Decoded general control
   typedef struct packed {
      logic       strobe_ds;
      logic       fwd_full_reread;
      logic       rev_empty_rewrite;
      logic       req_active_low;
      logic       ack_active_high;
      logic [2:0] ack_delay;
      logic       strobe_two;
      logic       clk_div2;
      logic       peripheral;
   } dfcr_ctl_type;
endpackage

// file: dfcr_flag_gen.sv
/*
 * Four flags of one FIFO array from its word count and offsets.
 * Assumes the count and alternate pointer-meet levels are synchronous.
 */
`timescale 1ns/1ps
module dfcr_flag_gen (
   // Clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        srst_in,
   // Fill state
   input  wire logic [dfcr_pkg::CW-1:0]     count_in,
   input  wire logic [dfcr_pkg::OFW-1:0]    ae_ofs_in,
   input  wire logic [dfcr_pkg::OFW-1:0]    af_ofs_in,
   // Alternate pointer-meet definitions
   input  wire logic                        alt_full_in,
   input  wire logic                        alt_empty_in,
   input  wire logic                        use_alt_full_in,
   input  wire logic                        use_alt_empty_in,
   // Flags
   output dfcr_pkg::dfcr_flags_type         flags_out
);
   import dfcr_pkg::*;

   typedef struct packed {
      dfcr_flags_type       flags;
      logic [CW-1:0]        cnt_d;
   } dfcr_fg_state_type;

   dfcr_fg_state_type state;
   dfcr_fg_state_type next_state;

   // Fixed flags follow the count one cycle later, almost flags two
   always_comb begin
      next_state = state;
      next_state.cnt_d = count_in;
      next_state.flags.empty = use_alt_empty_in ? alt_empty_in
                                                : (count_in == '0);
      next_state.flags.full  = use_alt_full_in ? alt_full_in
                                               : (count_in == DEPTH_CNT);
      next_state.flags.almost_empty = state.cnt_d <= {1'b0, ae_ofs_in};
      next_state.flags.almost_full  =
         state.cnt_d >= (DEPTH_CNT - {1'b0, af_ofs_in});
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state <= '{flags: '{almost_empty: 1'b1, empty: 1'b1, default: 1'b0},
                    cnt_d: '0};
      end else begin
         state <= next_state;
      end
   end

   assign flags_out = state.flags;

   property p_empty_follow;
      @(posedge clk_in) disable iff (srst_in)
         !use_alt_empty_in |=> (flags_out.empty == ($past(count_in) == '0));
   endproperty
   a_empty_follow: assert property (p_empty_follow)
      else $error("empty flag does not follow count");

   sequence s_zero_twice;
      (count_in == '0) ##1 (count_in == '0);
   endsequence
   property p_ae_lag;
      @(posedge clk_in) disable iff (srst_in)
         s_zero_twice |=> flags_out.almost_empty;
   endproperty
   a_ae_lag: assert property (p_ae_lag)
      else $error("almost-empty missing after steady zero count");

   property p_full_exact;
      @(posedge clk_in) disable iff (srst_in)
         (!use_alt_full_in && count_in == DEPTH_CNT) |=> flags_out.full;
   endproperty
   a_full_exact: assert property (p_full_exact)
      else $error("full flag missing at depth");
endmodule

// file: dfcr_flag_route.sv
/*
 * Selects one of eight internal flags for each of four external flag pins.
 * Assumes the flag vector is ordered by selector code.
 */
`timescale 1ns/1ps
module dfcr_flag_route (
   // Clock and reset
   input  wire logic          clk_in,
   input  wire logic          srst_in,
   // Selection
   input  wire logic [15:0]   route_in,
   input  wire logic [7:0]    flags_in,
   // Pins a..d
   output logic      [3:0]    pins_out
);
   import dfcr_pkg::*;

   typedef struct packed {
      logic [3:0] pins;
   } dfcr_rt_state_type;

   dfcr_rt_state_type state;
   dfcr_rt_state_type next_state;
   logic [3:0]        pick;

   // One selector nibble per pin; codes above seven drive low
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         logic [SELW-1:0] sel;
         assign sel = route_in[g*SELW +: SELW];
         assign pick[g] = sel[SELW-1] ? 1'b0 : flags_in[sel[2:0]];
      end
   endgenerate

   // Registered pin values
   always_comb begin
      next_state = state;
      next_state.pins = pick;
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pins_out = state.pins;
endmodule

// file: dfcr_host_model.sv
/*
 * Host processor model on the primary port: single word reads and writes.
 * Assumes it shares clk_in with the register bank.
 */
`timescale 1ns/1ps
module dfcr_host_model (
   // Clock
   input  wire logic             clk_in,
   // Host port
   output dfcr_pkg::dfcr_bus_type bus_out,
   input  wire logic [15:0]      rdata_in
);
   import dfcr_pkg::*;

   initial bus_out = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: 2'h0, wdata: 16'h0000};

   // One word: held over the taking edge, then released with inverted lines
   task automatic xfer(input logic is_rd, input logic [1:0] a, input logic [15:0] wd,
                       output logic [15:0] q);
      @(posedge clk_in);
      bus_out <= '{cs: 1'b1, rd: is_rd, wr: ~is_rd, addr: a, wdata: wd};
      @(posedge clk_in);
      bus_out <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~wd};
      @(posedge clk_in);
      #1 q = rdata_in;
   endtask
endmodule

// file: dual_fifo_flag_and_control_regs_tb_top.sv
/*
 * Self-checking bench for the flag status and configuration registers.
 * Assumes the host model drives the port and the bench drives fill state.
 */
`timescale 1ns/1ps
module dual_fifo_flag_and_control_regs_tb_top;
   import dfcr_pkg::*;

   logic          clk_in = 1'b0;
   logic          srst_in = 1'b1;
   dfcr_bus_type  bus;
   logic [15:0]   rdata;
   logic [CW-1:0] fwd_cnt = 11'h000;
   logic [CW-1:0] rev_cnt = 11'h000;
   logic          meet_f = 1'b0;
   logic          meet_r = 1'b0;
   logic [5:0]    pio = 6'h00;
   logic [3:0]    pins;
   dfcr_ctl_type  ctl;
   logic          dma_dir;
   int            fail_count = 0;
   int            checks_done = 0;
   int            cycles = 0;
   int            seed = 75;
   logic [15:0]   q;
   logic [15:0]   g;
   logic [15:0]   rt;
   logic [9:0]    ofs [4];
   logic          exp_dir = 1'b0;
   logic          d;
   logic [3:0]    ef;
   logic [3:0]    er;

   // Clock generator
   always #10 clk_in = ~clk_in;

   dfcr_regs i_dut (
      .clk_in(clk_in), .srst_in(srst_in), .bus_in(bus), .rdata_out(rdata),
      .fwd_count_in(fwd_cnt), .rev_count_in(rev_cnt),
      .fwd_meet_reread_in(meet_f), .rev_meet_rewrite_in(meet_r),
      .pio_in(pio), .pio_out(), .pio_oe_out(), .ext_flag_pins_out(pins),
      .ctl_out(ctl), .dma_read_dir_out(dma_dir),
      .fwd_reset_out(), .rev_reset_out(), .dma_reset_out()
   );

   dfcr_host_model i_host (.clk_in(clk_in), .bus_out(bus), .rdata_in(rdata));

   // Flags {almost_full, full, almost_empty, empty} from a word count
   function automatic logic [3:0] fl(input logic [CW-1:0] c, input logic [9:0] n, m);
      fl = {c >= DEPTH_CNT - {1'b0, m}, c == DEPTH_CNT, c <= {1'b0, n}, c == 11'h000};
   endfunction

   // Status word from forward and reverse flags and direction
   function automatic logic [15:0] st(input logic [3:0] f, r, input logic dd);
      st = {r[1], r[0], f[3], f[2], 4'h0, r[3], r[2], f[1], f[0], dd, 3'h0};
   endfunction

   // Pin levels for a routing word; codes 8..15 give a low pin
   function automatic logic [3:0] pe(input logic [15:0] r, input logic [7:0] v);
      for (int p = 0; p < 4; p++) pe[p] = r[4*p+3] ? 1'b0 : v[r[4*p +: 3]];
   endfunction

   // Decoded control expected from a control word
   function automatic dfcr_ctl_type ce(input logic [15:0] w);
      ce = '{strobe_ds: w[0], fwd_full_reread: w[2], rev_empty_rewrite: w[3],
             req_active_low: w[4], ack_active_high: w[5],
             ack_delay: {1'b0, w[7:6]} + 3'h2, strobe_two: w[8], clk_div2: w[9],
             peripheral: w[10]};
   endfunction

   // Count corner picker
   function automatic logic [CW-1:0] pick(input int s, input logic [9:0] n, m);
      case (s % 7)
         0: pick = 11'h000;
         1: pick = {1'b0, n};
         2: pick = {1'b0, n} + 11'h001;
         3: pick = DEPTH_CNT - {1'b0, m};
         4: pick = DEPTH_CNT - {1'b0, m} - 11'h001;
         5: pick = DEPTH_CNT;
         default: pick = {1'b0, n ^ m};
      endcase
   endfunction

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic close_out();
      $display("Summary: %0d checks, %0d mismatches", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [15:0] w);
      logic [15:0] t;
      i_host.xfer(1'b0, a, w, t);
   endtask

   task automatic cfg_wr(input logic [2:0] k, input logic [15:0] w);
      wr(ADDR_CMD, {10'h000, OP_SEL, k});
      wr(ADDR_CFG, w);
   endtask

   task automatic cfg_rd(input logic [2:0] k, output logic [15:0] r);
      wr(ADDR_CMD, {10'h000, OP_SEL, k});
      i_host.xfer(1'b1, ADDR_CFG, 16'h0000, r);
   endtask

   // Default contents of configuration registers 0..5
   task automatic chk_dflt();
      logic [15:0] r;
      for (int k = 0; k < 6; k++) begin
         cfg_rd(k[2:0], r);
         chk("config default", (k == 4) ? ROUTE_RST : ZERO16, r);
      end
   endtask

   // Hang guard
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 8000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      chk_dflt();
      $display("Test hardware reset defaults done");
      // Offsets and control readback, all-ones word first
      for (int i = 0; i < 6; i++) begin
         g = (i == 0) ? 16'hffff : 16'($random(seed));
         for (int k = 0; k < 4; k++) begin
            cfg_wr(k[2:0], g);
            cfg_rd(k[2:0], q);
            chk("offset", g & 16'h03ff, q);
         end
         cfg_wr(CR_GCTL, g);
         cfg_rd(CR_GCTL, q);
         chk("control", g & GC_MASK, q);
         chk("ctl out", {5'h00, ce(g)}, {5'h00, ctl});
      end
      $display("Test register readback done");
      wr(ADDR_CMD, {10'h000, OP_RST, RST_ALL});
      chk_dflt();
      $display("Test reset-all defaults done");
      // Flags, status, routing and direction over count corners
      for (int i = 0; i < 14; i++) begin
         for (int k = 0; k < 4; k++) begin
            ofs[k] = 10'($random(seed));
            if (i == 12) ofs[k][9] = 1'b0;
            cfg_wr(k[2:0], {6'h00, ofs[k]});
         end
         rt = 16'($random(seed)) & 16'h7777;
         if (i == 13) rt = rt | 16'h8000;
         cfg_wr(CR_ROUTE, rt);
         // Peripheral mode on odd passes, alternate pointer-meet flags on every other pair
         g = {5'h00, i[0], 6'h00, i[1], i[1], 2'h0};
         cfg_wr(CR_GCTL, g);
         d = 1'($random(seed));
         wr(ADDR_CMD, {10'h000, OP_DIR, 2'h0, d});
         if (i[0]) exp_dir = d;
         @(posedge clk_in);
         fwd_cnt <= pick(i, ofs[0], ofs[1]);
         rev_cnt <= pick(i + 3, ofs[2], ofs[3]);
         meet_f <= 1'($random(seed));
         meet_r <= 1'($random(seed));
         pio <= 6'($random(seed));
         repeat (4) @(posedge clk_in);
         ef = fl(fwd_cnt, ofs[0], ofs[1]);
         er = fl(rev_cnt, ofs[2], ofs[3]);
         if (g[GC_FULL]) ef[2] = meet_f;
         if (g[GC_EMPTY]) er[0] = meet_r;
         i_host.xfer(1'b1, ADDR_CMD, 16'h0000, q);
         chk("status", st(ef, er, exp_dir), q);
         chk("pins", {12'h000, pe(rt, {er, ef})}, {12'h000, pins});
         chk("direction", {15'h0000, exp_dir}, {15'h0000, dma_dir});
      end
      $display("Test flags and routing done");
      // Mid-run hardware reset over non-default contents
      @(posedge clk_in);
      srst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      chk_dflt();
      chk("direction after reset", ZERO16, {15'h0000, dma_dir});
      $display("Test mid-run reset done");
      close_out();
   end
endmodule
